/* hw/sspb_burst_step.sv */
`timescale 1ns/1ps
`default_nettype none
module sspb_burst_step
	import sspb_pkg::*;
(
	input wire logic [BURST_W-1:0] i_base,
	input wire logic [BURST_W-1:0] i_count,
	input wire logic i_order,
	output logic [BURST_W-1:0] o_low
);
	// ------------------------------------------------------------
	// Interleaved or linear step of the two low address bits
	// ------------------------------------------------------------
	always_comb begin
		if (i_order == ORDER_INTERLEAVED) begin
			o_low = i_base ^ i_count;
		end else begin
			o_low = i_base + i_count;
		end
	end
endmodule
`default_nettype wire

/* hw/sspb_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sspb_fifo
	import sspb_pkg::*;
#(
	parameter int W = WR_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_reg [DEPTH];
	logic [W-1:0] mem_next [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign o_in_ready = cnt_reg != (AW+1)'(DEPTH);
	assign o_out_valid = cnt_reg != '0;
	assign o_out_data = mem_reg[rp_reg];

	// ------------------------------------------------------------
	// Pointer and storage update
	// ------------------------------------------------------------
	always_comb begin
		push = i_en & i_in_valid & o_in_ready;
		pop = i_en & o_out_valid & i_out_ready;
		mem_next = mem_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		if (push) begin
			mem_next[wp_reg] = i_in_data;
			wp_next = wp_reg + 1'b1;
		end
		if (pop) begin
			rp_next = rp_reg + 1'b1;
		end
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		mem_reg <= mem_next;
	end
endmodule
`default_nettype wire

/* hw/sspb_pkg.sv */
`default_nettype none
package sspb_pkg;
	// ------------------------------------------------------------
	// Widths and storage
	// ------------------------------------------------------------
	localparam int DATA_W = 36;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int ADDR_W = 17;
	localparam int BURST_W = 2;
	localparam int ARRAY_AW = 4;
	localparam int ARRAY_DEPTH = 16;
	localparam int FIFO_DEPTH = 16;

	// ------------------------------------------------------------
	// Pin encodings and reset values
	// ------------------------------------------------------------
	localparam logic RW_READ = 1'b1;
	localparam logic ADV_LOAD = 1'b0;
	localparam logic ORDER_INTERLEAVED = 1'b1;
	localparam logic [DATA_W-1:0] DQ_RESET = 36'h0;
	localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int READ_LATENCY_EDGES = 2;
	localparam int WRITE_LATENCY_EDGES = 2;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic we;
		logic [LANES-1:0] lane_en;
		logic [ADDR_W-1:0] addr;
	} sspb_cmd_t;

	typedef struct packed {
		logic [ARRAY_AW-1:0] idx;
		logic [LANES-1:0] lane_en;
		logic [DATA_W-1:0] data;
	} sspb_wr_t;

	localparam int WR_W = $bits(sspb_wr_t);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RD = 3'b010,
		ST_WR = 3'b100
	} sspb_state_t;
endpackage
`default_nettype wire

/* hw/sspb_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A load edge ends any running burst and takes new address and control.
// - While continuing a burst, the read/write pin is ignored.
// - Burst direction is fixed by read/write level on the load edge.
// - Read/write low on a load starts a write, high starts a read.
// - Byte selects travel with the address; write data follows two edges later.
// - Clock gate high freezes every internal register except the two reset-release flops for that edge.
// - Bursts step only the two low address bits, interleaved or linear.
// - Data outputs stay undriven from reset until a read delivers data.
// - Deselected load starts nothing, but a pipelined read still completes.
module sspb_port
	import sspb_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_clock_gate_input,
	input wire logic i_burst_continue_or_load,
	input wire logic i_rw,
	input wire logic i_chip_select_low_a_n,
	input wire logic i_chip_select_low_b_n,
	input wire logic i_chip_select_high,
	input wire logic [LANES-1:0] i_byte_write_selects_n,
	input wire logic i_burst_order_select,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_output_enable_n,
	input wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	output logic o_write_ready
);
	function automatic logic chip_selected(input logic a_n, input logic b_n, input logic hi);
		chip_selected = !a_n && !b_n && hi;
	endfunction

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_reg, rst_sync_reg;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sspb_state_t state_reg, state_next;
	sspb_cmd_t s1_reg, s1_next, s2_reg, s2_next;
	logic [ADDR_W-1:0] base_reg, base_next;
	logic [BURST_W-1:0] cnt_reg, cnt_next;
	logic [DATA_W-1:0] dq_reg, dq_next;
	logic drive_reg, drive_next;
	logic [DATA_W-1:0] arr_reg [ARRAY_DEPTH];
	logic [DATA_W-1:0] arr_next [ARRAY_DEPTH];

	logic en, load, sel, rd_now;
	logic [BURST_W-1:0] cnt_step, low_step;
	sspb_wr_t push_data, pop_data;
	logic push_valid, pop_valid, pop_ready;
	logic [DATA_W-1:0] merged;

	assign en = !i_clock_gate_input;
	assign load = i_burst_continue_or_load == ADV_LOAD;
	assign sel = chip_selected(i_chip_select_low_a_n, i_chip_select_low_b_n, i_chip_select_high);
	assign cnt_step = cnt_reg + 1'b1;
	assign rd_now = s1_reg.valid && !s1_reg.we;

	sspb_burst_step i_sspb_burst_step (
		.i_base(base_reg[BURST_W-1:0]),
		.i_count(cnt_step),
		.i_order(i_burst_order_select),
		.o_low(low_step)
	);

	// ------------------------------------------------------------
	// Write commit buffer
	// ------------------------------------------------------------
	assign push_valid = s2_reg.valid && s2_reg.we;
	assign push_data = '{idx: s2_reg.addr[ARRAY_AW-1:0], lane_en: s2_reg.lane_en, data: i_dq};
	assign pop_ready = !rd_now;

	sspb_fifo #(
		.W(WR_W),
		.DEPTH(FIFO_DEPTH)
	) i_sspb_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_sync_reg),
		.i_en(en),
		.i_in_valid(push_valid),
		.o_in_ready(o_write_ready),
		.i_in_data(push_data),
		.o_out_valid(pop_valid),
		.i_out_ready(pop_ready),
		.o_out_data(pop_data)
	);

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign merged[g*LANE_W +: LANE_W] = pop_data.lane_en[g] ? pop_data.data[g*LANE_W +: LANE_W]
			: arr_reg[pop_data.idx][g*LANE_W +: LANE_W];
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		s1_next = s1_reg;
		s2_next = s2_reg;
		base_next = base_reg;
		cnt_next = cnt_reg;
		dq_next = dq_reg;
		drive_next = drive_reg;
		arr_next = arr_reg;
		if (en) begin
			if (load) begin
				if (sel) begin
					state_next = (i_rw == RW_READ) ? ST_RD : ST_WR;
					base_next = i_addr;
					cnt_next = BURST_FIRST;
					s1_next = '{valid: 1'b1, we: i_rw != RW_READ, lane_en: ~i_byte_write_selects_n, addr: i_addr};
				end else begin
					state_next = ST_IDLE;
					s1_next.valid = 1'b0;
				end
			end else begin
				case (state_reg)
					ST_RD, ST_WR: begin
						cnt_next = cnt_step;
						s1_next.valid = 1'b1;
						s1_next.we = state_reg == ST_WR;
						s1_next.lane_en = ~i_byte_write_selects_n;
						s1_next.addr = {base_reg[ADDR_W-1:BURST_W], low_step};
					end
					ST_IDLE: begin
						s1_next.valid = 1'b0;
					end
					default: begin
						state_next = ST_IDLE;
						s1_next.valid = 1'b0;
					end
				endcase
			end
			s2_next = s1_reg;
			drive_next = rd_now;
			if (rd_now) begin
				dq_next = arr_reg[s1_reg.addr[ARRAY_AW-1:0]];
			end
			if (pop_valid && pop_ready) begin
				arr_next[pop_data.idx] = merged;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg <= ST_IDLE;
			s1_reg <= '0;
			s2_reg <= '0;
			base_reg <= '0;
			cnt_reg <= BURST_FIRST;
			dq_reg <= DQ_RESET;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			base_reg <= base_next;
			cnt_reg <= cnt_next;
			dq_reg <= dq_next;
			drive_reg <= drive_next;
		end
	end

	always_ff @(posedge i_core_clk) begin
		arr_reg <= arr_next;
	end

	// ------------------------------------------------------------
	// Data pins
	// ------------------------------------------------------------
	assign o_dq = dq_reg;
	assign o_dq_oe = drive_reg && !i_output_enable_n;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_sync_reg);

	property p_load_dir;
		en && load && sel |=> state_reg == ($past(i_rw) == RW_READ ? ST_RD : ST_WR) && s1_reg.valid
			&& s1_reg.we == ($past(i_rw) != RW_READ);
	endproperty
	a_load_dir: assert property (p_load_dir) else $error("load direction wrong");

	property p_burst_hold_dir;
		en && !load && state_reg == ST_WR ##1 en && !load |=> state_reg == ST_WR && s1_reg.we;
	endproperty
	a_burst_hold_dir: assert property (p_burst_hold_dir) else $error("burst direction changed");

	property p_ignore_rw;
		en && !load && state_reg == ST_RD |=> state_reg == ST_RD && !s1_reg.we;
	endproperty
	a_ignore_rw: assert property (p_ignore_rw) else $error("read/write not ignored in burst");

	property p_deselect;
		en && load && !sel |=> state_reg == ST_IDLE && !s1_reg.valid;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselected load started access");

	property p_freeze;
		!en |=> $stable(state_reg) && $stable(s1_reg) && $stable(s2_reg) && $stable(dq_reg) && $stable(drive_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while gated");

	property p_burst_addr;
		en && !load && state_reg != ST_IDLE |=> s1_reg.addr[ADDR_W-1:BURST_W] == $past(base_reg[ADDR_W-1:BURST_W])
			&& cnt_reg == $past(cnt_reg) + 2'h1;
	endproperty
	a_burst_addr: assert property (p_burst_addr) else $error("burst touched high address bits");

	property p_read_latency;
		en && load && sel && i_rw == RW_READ ##1 en |=> drive_reg;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read data not driven on time");

	property p_pending_read;
		en && rd_now |=> drive_reg && dq_reg == $past(arr_reg[s1_reg.addr[ARRAY_AW-1:0]]);
	endproperty
	a_pending_read: assert property (p_pending_read) else $error("pipelined read lost");

	property p_hiz;
		en && !rd_now |=> !o_dq_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven without read");

	property p_write_push;
		en && load && sel && i_rw != RW_READ ##1 en ##1 en |-> push_valid
			&& push_data.lane_en == ~$past(i_byte_write_selects_n, 2);
	endproperty
	a_write_push: assert property (p_write_push) else $error("write data not taken two edges later");

	property p_load_addr;
		en && load && sel |=> s1_reg.addr == $past(i_addr) && cnt_reg == BURST_FIRST;
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("load did not take new address");

	property p_write_dir;
		en && load && sel && i_rw != RW_READ |=> state_reg == ST_WR && s1_reg.we;
	endproperty
	a_write_dir: assert property (p_write_dir) else $error("low read/write did not start a write");

	property p_burst_lanes;
		en && !load && state_reg == ST_WR |=> s1_reg.lane_en == ~$past(i_byte_write_selects_n);
	endproperty
	a_burst_lanes: assert property (p_burst_lanes) else $error("burst beat lost its byte selects");

	property p_order_interleaved;
		en && !load && state_reg != ST_IDLE && i_burst_order_select == ORDER_INTERLEAVED
			|=> s1_reg.addr[BURST_W-1:0] == ($past(base_reg[BURST_W-1:0]) ^ $past(cnt_step));
	endproperty
	a_order_interleaved: assert property (p_order_interleaved) else $error("interleaved step wrong");

	property p_order_linear;
		en && !load && state_reg != ST_IDLE && i_burst_order_select != ORDER_INTERLEAVED
			|=> s1_reg.addr[BURST_W-1:0] == $past(base_reg[BURST_W-1:0]) + $past(cnt_step);
	endproperty
	a_order_linear: assert property (p_order_linear) else $error("linear step wrong");

	property p_idle_continue;
		en && !load && state_reg == ST_IDLE |=> !s1_reg.valid && state_reg == ST_IDLE;
	endproperty
	a_idle_continue: assert property (p_idle_continue) else $error("continue while idle started access");

	property p_deselect_read;
		en && load && !sel && rd_now |=> drive_reg;
	endproperty
	a_deselect_read: assert property (p_deselect_read) else $error("deselect dropped pending read");

	property p_freeze_burst;
		!en |=> $stable(base_reg) && $stable(cnt_reg);
	endproperty
	a_freeze_burst: assert property (p_freeze_burst) else $error("burst counter moved while gated");
endmodule
`default_nettype wire

/* sim/sspb_ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sspb_ctl_model
	import sspb_pkg::*;
(
	input wire logic i_core_clk,
	output logic o_gate,
	output logic o_adv,
	output logic o_rw,
	output logic o_csa_n,
	output logic o_csb_n,
	output logic o_csh,
	output logic [LANES-1:0] o_bw_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq
);
	logic wr_burst = 1'b0;
	logic w1_v = 1'b0;
	logic [DATA_W-1:0] w1_d = '0;
	logic [DATA_W-1:0] cur = '0;

	initial begin
		o_gate = 1'b0;
		o_adv = ADV_LOAD;
		o_rw = RW_READ;
		o_csa_n = 1'b1;
		o_csb_n = 1'b1;
		o_csh = 1'b0;
		o_bw_n = '1;
		o_addr = '0;
		o_dq = '0;
	end

	// ------------------------------------------------------------
	// One pin beat, launched just after an edge
	// ------------------------------------------------------------
	task automatic beat(input logic adv, input logic rw, input logic sel, input logic g,
			input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
		@(posedge i_core_clk);
		o_adv <= adv;
		o_rw <= rw;
		o_gate <= g;
		o_addr <= a;
		o_bw_n <= m;
		cur <= d;
		o_csa_n <= !sel;
		o_csb_n <= !sel;
		o_csh <= sel;
	endtask

	// ------------------------------------------------------------
	// Write data two ungated edges after its beat
	// ------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (!o_gate) begin
			if (o_adv == ADV_LOAD)
				wr_burst <= o_csh && o_rw != RW_READ;
			w1_v <= (o_adv == ADV_LOAD) ? (o_csh && o_rw != RW_READ) : wr_burst;
			w1_d <= cur;
			o_dq <= w1_v ? w1_d : ~o_dq;
		end
	end
endmodule
`default_nettype wire

/* sim/sspb_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sspb_port_tb;
	import sspb_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic order = 1'b0;
	logic oe_n = 1'b0;
	logic gate, adv, rw, csa_n, csb_n, csh, dq_oe, wr_rdy;
	logic [LANES-1:0] bw_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq_in, dq_out;
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] rq [$];
	logic [DATA_W-1:0] exp_q [$];
	int failures = 0;
	int cmp_count = 0;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	sspb_ctl_model i_sspb_ctl_model (.i_core_clk(clk), .o_gate(gate), .o_adv(adv), .o_rw(rw), .o_csa_n(csa_n),
		.o_csb_n(csb_n), .o_csh(csh), .o_bw_n(bw_n), .o_addr(addr), .o_dq(dq_in));
	sspb_port i_sspb_port (.i_core_clk(clk), .i_nrst(nrst), .i_clock_gate_input(gate),
		.i_burst_continue_or_load(adv), .i_rw(rw), .i_chip_select_low_a_n(csa_n), .i_chip_select_low_b_n(csb_n),
		.i_chip_select_high(csh), .i_byte_write_selects_n(bw_n), .i_burst_order_select(order), .i_addr(addr),
		.i_output_enable_n(oe_n), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe), .o_write_ready(wr_rdy));

	// Capture each delivered word once, skipping frozen edges
	always @(negedge clk) begin
		if (dq_oe === 1'b1 && gate !== 1'b1)
			rq.push_back(dq_out);
	end

	task automatic stop_test;
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Shared beats
	// ------------------------------------------------------------
	task automatic b(input logic v, input logic r, input logic s, input logic g,
			input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
		i_sspb_ctl_model.beat(v, r, s, g, a, m, d);
	endtask

	task automatic idle(input int n);
		repeat (n) b(1'b0, 1'b1, 1'b0, 1'b0, '0, '1, '0);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
		for (int g = 0; g < LANES; g++)
			if (!m[g])
				mem[a[3:0]][g*LANE_W +: LANE_W] = d[g*LANE_W +: LANE_W];
		b(1'b0, 1'b0, 1'b1, 1'b0, a, m, d);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		exp_q.push_back(mem[a[3:0]]);
		b(1'b0, 1'b1, 1'b1, 1'b0, a, '1, '0);
	endtask

	task automatic burst(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [3:0] ix;
		for (int k = 0; k < 4; k++) begin
			ix = {a[3:2], order ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
			if (w)
				mem[ix] = d + DATA_W'(k);
			else
				exp_q.push_back(mem[ix]);
			b(k != 0, (k == 0) ? !w : w, 1'b1, 1'b0, a, '0, d + DATA_W'(k));
		end
	endtask

	task automatic check_reads;
		logic [DATA_W-1:0] g, e;
		int n;
		idle(4);
		n = 0;
		while (wr_rdy !== 1'b1) begin
			if (++n > 50) begin
				failures++;
				stop_test();
			end
			@(posedge clk);
		end
		`CHK(rq.size(), exp_q.size())
		while (rq.size() > 0 && exp_q.size() > 0) begin
			g = rq.pop_front();
			e = exp_q.pop_front();
			`CHK(g, e)
		end
		rq.delete();
		exp_q.delete();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_rw;
		wr(17'h0, 4'h0, 36'h1_2345_6789);
		wr(17'h1_0002, 4'h0, 36'hf_0f0f_0f0f);
		wr(17'h2, 4'ha, 36'h5_a5a5_a5a5);
		idle(6);
		rd(17'h1_fff2);
		wr(17'h5, 4'h0, 36'h3_3333_3333);
		rd(17'h0);
		idle(6);
		rd(17'h5);
		check_reads();
	endtask

	task automatic s_burst;
		for (int o = 0; o < 2; o++) begin
			order <= o[0];
			burst(1'b1, 17'h4, 36'h100 + DATA_W'(o * 16));
			idle(6);
			burst(1'b0, 17'h5, '0);
			rd(17'h4);
			check_reads();
		end
	endtask

	task automatic s_gate;
		wr(17'h9, 4'h0, 36'h9_9999_0000);
		b(1'b0, 1'b0, 1'b1, 1'b1, 17'h8, 4'h0, '0);
		idle(6);
		rd(17'h9);
		b(1'b0, 1'b1, 1'b1, 1'b1, 17'h0, '1, '0);
		b(1'b0, 1'b1, 1'b1, 1'b1, 17'h0, '1, '0);
		check_reads();
	endtask

	task automatic s_desel;
		rd(17'h2);
		idle(1);
		repeat (3) b(1'b1, 1'b1, 1'b1, 1'b0, 17'h0, '1, '0);
		check_reads();
	endtask

	task automatic s_oe;
		rd(17'h0);
		idle(1);
		@(negedge clk);
		`CHK(dq_oe, 1'b0)
		@(negedge clk);
		`CHK(dq_oe, 1'b1)
		@(posedge clk);
		oe_n <= 1'b1;
		rd(17'h0);
		void'(exp_q.pop_back());
		idle(3);
		oe_n <= 1'b0;
		check_reads();
	endtask

	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(dq_oe, 1'b0)
		`CHK(dq_out, DQ_RESET)
		`CHK(wr_rdy, 1'b1)
		s_rw();
		s_burst();
		s_gate();
		s_desel();
		s_oe();
		stop_test();
	end
endmodule
`default_nettype wire
